// [hdl/hub_rst_pkg.sv]
// constants for the hub reset and link power sequencer
// assumes a 100 MHz core clock
package hub_rst_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  // power-on hold interval in microseconds
  localparam int unsigned POR_HOLD_US    = 100;
  localparam int unsigned POR_HOLD_CYC   = POR_HOLD_US * CLK_MHZ;
  // oscillator and pll settle after reset release, in cycles
  localparam int unsigned OSC_SETTLE_CYC = 16;
  // link power latencies
  localparam int unsigned L1_ENTRY_NS    = 10000;
  localparam int unsigned L1_EXIT_NS     = 50000;
  localparam int unsigned L2_ENTRY_US    = 3000;
  localparam int unsigned L2_EXIT_US     = 2000;
  // longest times round down, less one so the bound is strictly met
  localparam int unsigned L1_ENTRY_CYC   = L1_ENTRY_NS / 10 - 1;
  localparam int unsigned L1_EXIT_CYC    = L1_EXIT_NS / 10 - 1;
  localparam int unsigned L2_ENTRY_CYC   = L2_ENTRY_US * CLK_MHZ;
  localparam int unsigned L2_EXIT_CYC    = L2_EXIT_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 20;
  localparam logic [6:0]  ADDR_DEFAULT   = 7'h00;
  typedef enum logic [2:0] {
    LINK_L0, LINK_L1_ENTER, LINK_L1, LINK_L1_EXIT,
    LINK_L2_ENTER, LINK_L2, LINK_L2_EXIT
  } link_state_t;
endpackage : hub_rst_pkg

// [hdl/hub_rst_sync.sv]
// reset synchroniser: asserts at once, releases after two clock edges
// assumes clk runs whenever the release is to be seen
`timescale 1ns/1ps
`default_nettype none
module hub_rst_sync
(
  // clock and raw reset
  input  wire logic clk,
  input  wire logic arst_b,
  // synchronised reset
  output var  logic srst_b
);
  logic meta_q;
  logic meta_d;
  logic out_q;
  logic out_d;

  // shift a one in behind the release
  always_comb
  begin
    meta_d = 1'b1;
    out_d  = meta_q;
  end

  // constants only under reset
  always_ff @(posedge clk or negedge arst_b)
  begin
    if (!arst_b)
    begin
      meta_q <= 1'b0;
      out_q  <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign srst_b = out_q;
endmodule : hub_rst_sync
`default_nettype wire

// [hdl/hub_reset_and_link_power.sv]
// chip reset combiner, usb bus reset effects and link power states
// assumes the clock stops while rst_b is low and bus inputs are synchronous
//
// Operation
// - Power-on, the external reset pin and upstream bus reset are the three reset sources.
// - Power-on raises internal reset and a timer holds it for a fixed interval.
// - While the pin is low the device sits in low-current standby.
// - The pin disables the transceiver and floats every differential pair.
// - The pin aborts every transaction at once and keeps no prior state.
// - The pin returns every internal register to its default.
// - The pin stops the oscillator and pll so no clock runs during it.
// - Bus reset sets the device address back to zero.
// - Bus reset returns the configuration to unconfigured.
// - Bus reset while suspended brings the device back to active.
// - Bus reset on the upstream port is never forwarded downstream.
// - Three link states exist: on, sleep and suspend.
// - Sleep entry completes under 10 us and sleep exit under 50 us.
// - Suspend entry takes about 3 ms and exit about 2 ms from resume start.
`timescale 1ns/1ps
`default_nettype none
module hub_reset_and_link_power
#(
  parameter int unsigned POR_CYC    = hub_rst_pkg::POR_HOLD_CYC,
  parameter int unsigned L2_IN_CYC  = hub_rst_pkg::L2_ENTRY_CYC,
  parameter int unsigned L2_OUT_CYC = hub_rst_pkg::L2_EXIT_CYC
)
(
  // clock and external reset pin
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // power-on detector level, high while supply is below threshold
  input  wire logic                     por_raw,
  // upstream usb events
  input  wire logic                     bus_reset,
  input  wire logic                     set_address,
  input  wire logic [6:0]               new_address,
  input  wire logic                     set_config,
  input  wire logic                     sleep_req,
  input  wire logic                     suspend_req,
  input  wire logic                     resume_req,
  // clock source control
  output logic                          osc_en,
  output logic                          pll_en,
  output logic                          standby,
  // transceiver control
  output logic                          phy_en,
  output logic                          pair_oe,
  // internal resets
  output logic                          core_rst_b,
  output logic                          usb_rst_b,
  output logic                          abort,
  output logic                          dn_reset,
  // usb device state
  output logic [6:0]                    dev_address,
  output logic                          configured,
  output logic                          suspended,
  output hub_rst_pkg::link_state_t      link_state,
  output logic                          link_busy
);
  import hub_rst_pkg::*;

  // reset path
  logic                     por_b;
  logic                     sync_b;

  // power-on hold timer
  logic [CNT_W-1:0]         por_cnt_q;
  logic [CNT_W-1:0]         por_cnt_d;
  logic                     por_done_q;
  logic                     por_done_d;

  // oscillator and pll settle wait
  logic [4:0]               settle_q;
  logic [4:0]               settle_d;
  logic                     clk_ok_q;
  logic                     clk_ok_d;

  // usb device state
  logic [6:0]               addr_q;
  logic [6:0]               addr_d;
  logic                     cfg_q;
  logic                     cfg_d;

  // link power state
  link_state_t              st_q;
  link_state_t              st_d;
  logic [CNT_W-1:0]         lcnt_q;
  logic [CNT_W-1:0]         lcnt_d;

  // cycle count at counter width
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n);
  endfunction : cyc

  // entry and exit legs are the timed transit states
  function automatic logic in_transit(input link_state_t s);
    in_transit = (s == LINK_L1_ENTER) || (s == LINK_L1_EXIT) ||
                 (s == LINK_L2_ENTER) || (s == LINK_L2_EXIT);
  endfunction : in_transit

  // pin or power-on asserts at once, release is synchronous
  assign por_b = rst_b & ~por_raw;
  hub_rst_sync u_sync
  (
    .clk    (clk),
    .arst_b (por_b),
    .srst_b (sync_b)
  );

  // clock sources stop while the pin is low
  assign osc_en  = rst_b;
  assign pll_en  = rst_b;
  assign standby = ~rst_b;

  // power-on hold timer and clock settle wait
  always_comb
  begin
    por_cnt_d  = por_cnt_q;
    por_done_d = por_done_q;
    settle_d   = settle_q;
    clk_ok_d   = clk_ok_q;
    if (!clk_ok_q)
    begin
      if (settle_q == 5'(OSC_SETTLE_CYC - 1))
        clk_ok_d = 1'b1;
      else
        settle_d = settle_q + 5'h01;
    end
    if (!por_done_q)
    begin
      if (por_cnt_q == cyc(POR_CYC - 1))
        por_done_d = 1'b1;
      else
        por_cnt_d = por_cnt_q + cyc(1);
    end
  end

  // timer state clears on any chip reset
  always_ff @(posedge clk or negedge sync_b)
  begin
    if (!sync_b)
    begin
      por_cnt_q  <= '0;
      por_done_q <= 1'b0;
      settle_q   <= 5'h00;
      clk_ok_q   <= 1'b0;
    end
    else
    begin
      por_cnt_q  <= por_cnt_d;
      por_done_q <= por_done_d;
      settle_q   <= settle_d;
      clk_ok_q   <= clk_ok_d;
    end
  end

  // chip resets: bus reset joins only the usb reset
  assign core_rst_b = sync_b & por_done_q & clk_ok_q;
  assign usb_rst_b  = core_rst_b & ~bus_reset;
  assign abort      = ~core_rst_b;
  assign phy_en     = core_rst_b;
  assign pair_oe    = core_rst_b;
  assign dn_reset   = 1'b0;

  // address and configuration state
  always_comb
  begin
    addr_d = addr_q;
    cfg_d  = cfg_q;
    if (bus_reset)
    begin
      addr_d = ADDR_DEFAULT;
      cfg_d  = 1'b0;
    end
    else
    begin
      if (set_address)
        addr_d = new_address;
      if (set_config)
        cfg_d = 1'b1;
    end
    // nothing is kept while the chip is still held in reset
    if (!core_rst_b)
    begin
      addr_d = ADDR_DEFAULT;
      cfg_d  = 1'b0;
    end
  end

  // registers default on chip reset
  always_ff @(posedge clk or negedge sync_b)
  begin
    if (!sync_b)
    begin
      addr_q <= ADDR_DEFAULT;
      cfg_q  <= 1'b0;
    end
    else
    begin
      addr_q <= addr_d;
      cfg_q  <= cfg_d;
    end
  end

  // link power state machine with timed transitions
  always_comb
  begin
    st_d   = st_q;
    lcnt_d = lcnt_q + cyc(1);
    unique case (st_q)
      LINK_L0:
      begin
        lcnt_d = '0;
        if (suspend_req)
          st_d = LINK_L2_ENTER;
        else if (sleep_req)
          st_d = LINK_L1_ENTER;
      end
      LINK_L1_ENTER:
      begin
        if (lcnt_q == cyc(L1_ENTRY_CYC - 1))
        begin
          st_d   = LINK_L1;
          lcnt_d = '0;
        end
      end
      LINK_L1:
      begin
        lcnt_d = '0;
        if (resume_req)
          st_d = LINK_L1_EXIT;
      end
      LINK_L1_EXIT:
      begin
        if (lcnt_q == cyc(L1_EXIT_CYC - 1))
        begin
          st_d   = LINK_L0;
          lcnt_d = '0;
        end
      end
      LINK_L2_ENTER:
      begin
        if (lcnt_q == cyc(L2_IN_CYC - 1))
        begin
          st_d   = LINK_L2;
          lcnt_d = '0;
        end
      end
      LINK_L2:
      begin
        lcnt_d = '0;
        if (resume_req)
          st_d = LINK_L2_EXIT;
      end
      LINK_L2_EXIT:
      begin
        if (lcnt_q == cyc(L2_OUT_CYC - 1))
        begin
          st_d   = LINK_L0;
          lcnt_d = '0;
        end
      end
      default:
      begin
        st_d   = LINK_L0;
        lcnt_d = '0;
      end
    endcase
    // bus reset wakes the device straight to active
    if (bus_reset)
    begin
      st_d   = LINK_L0;
      lcnt_d = '0;
    end
    // held chip reset parks the link in the on state
    if (!core_rst_b)
    begin
      st_d   = LINK_L0;
      lcnt_d = '0;
    end
  end

  // link state registers
  always_ff @(posedge clk or negedge sync_b)
  begin
    if (!sync_b)
    begin
      st_q   <= LINK_L0;
      lcnt_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      lcnt_q <= lcnt_d;
    end
  end

  // state outputs
  assign dev_address = addr_q;
  assign configured  = cfg_q;
  assign link_state  = st_q;
  assign suspended   = (st_q == LINK_L2);
  assign link_busy   = in_transit(st_q);
endmodule : hub_reset_and_link_power
`default_nettype wire

// [verif/hub_rst_props.sv]
// port checks for the reset and link power block
// bound into the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module hub_rst_props
(
  // clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic core_rst_b,
  input wire logic usb_rst_b,
  // watched signals
  input wire logic bus_reset,
  input wire logic osc_en,
  input wire logic pll_en,
  input wire logic standby,
  input wire logic phy_en,
  input wire logic pair_oe,
  input wire logic abort,
  input wire logic dn_reset,
  input wire logic [6:0] dev_address,
  input wire logic configured,
  input wire logic suspended,
  input wire hub_rst_pkg::link_state_t link_state
);
  import hub_rst_pkg::*;

  // pin reset masks every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_sync_release:
    assert property ($rose(rst_b) |-> !core_rst_b [*2])
    else $error("core reset left early");
  a_pair_float:
    assert property (phy_en == core_rst_b && pair_oe == core_rst_b)
    else $error("pairs driven in reset");
  a_abort_now:
    assert property (abort != core_rst_b)
    else $error("abort not tied to reset");
  a_no_forward:
    assert property (!dn_reset)
    else $error("reset sent downstream");
  a_clock_run:
    assert property (osc_en && pll_en && !standby)
    else $error("clocks idle out of reset");
  a_bus_default:
    assert property (core_rst_b && bus_reset |=>
      dev_address == 7'h00 && !configured)
    else $error("bus reset kept state");
  a_bus_wake:
    assert property (core_rst_b && bus_reset && suspended |=>
      !suspended && link_state == LINK_L0)
    else $error("bus reset left suspend");
  a_usb_only:
    assert property (bus_reset |-> !usb_rst_b && osc_en)
    else $error("bus reset scope wrong");
  a_sleep_fast:
    assert property ($rose(link_state == LINK_L1_ENTER) |->
      ##[1:999] link_state == LINK_L1)
    else $error("sleep entry too slow");
endmodule : hub_rst_props

bind hub_reset_and_link_power hub_rst_props u_props (.clk, .rst_b,
  .core_rst_b, .usb_rst_b, .bus_reset, .osc_en, .pll_en, .standby, .phy_en,
  .pair_oe, .abort, .dn_reset, .dev_address, .configured, .suspended,
  .link_state);
`default_nettype wire

// [verif/host_enum_model.sv]
// host model: enumerates the hub after each bus reset
// assumes bus_reset changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_enum_model
#(
  parameter logic [6:0] ADDR = 7'h01
)
(
  // clock and bus reset
  input  wire logic       clk,
  input  wire logic       bus_reset,
  // enumeration requests
  output var  logic       set_address,
  output var  logic [6:0] new_address,
  output var  logic       set_config
);
  // idle at time zero
  logic       bus_reset_q = 1'b0;
  logic       set_addr_q  = 1'b0;
  logic [6:0] addr_q      = 7'h00;
  logic       set_cfg_q   = 1'b0;
  // address after reset ends, then configuration; data toggles when idle
  always @(posedge clk)
  begin
    bus_reset_q <= bus_reset;
    set_addr_q  <= bus_reset_q && !bus_reset;
    set_cfg_q   <= set_addr_q;
    addr_q      <= (bus_reset_q && !bus_reset) ? ADDR : ~addr_q;
  end
  // one driver per request line
  assign set_address = set_addr_q;
  assign new_address = addr_q;
  assign set_config  = set_cfg_q;
endmodule : host_enum_model
`default_nettype wire

// [verif/tb_hub_reset_and_link_power.sv]
// self-checking bench for the reset and link power block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_hub_reset_and_link_power;
  import hub_rst_pkg::*;
  typedef struct packed {logic [3:0] req; int max; link_state_t exp;} row_t;
  // bench inputs
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_raw = 1'b0;
  logic bus_reset = 1'b0;
  logic sleep_req = 1'b0;
  logic suspend_req = 1'b0;
  logic resume_req = 1'b0;
  // outputs of design and host
  logic set_address, set_config, osc_en, pll_en, standby, phy_en;
  logic pair_oe, core_rst_b, usb_rst_b, abort, dn_reset, configured;
  logic suspended, link_busy;
  logic [6:0] new_address, dev_address;
  link_state_t link_state;
  int errors = 0;
  int checks = 0;
  // power-on hold long enough to outlast the clock settle wait
  localparam int POR_T = 30;
  wire logic [6:0] pins = {osc_en, pll_en, standby, phy_en, pair_oe, abort,
    dn_reset};
  wire logic [6:0] bus_pins = {3'h0, dn_reset, usb_rst_b, osc_en,
    core_rst_b};
  // req bits: bus reset, resume, suspend, sleep
  row_t rows [13] = '{
    '{4'h1, 0, LINK_L1_ENTER}, '{4'h0, 999, LINK_L1},
    '{4'h4, 0, LINK_L1_EXIT}, '{4'h0, 4999, LINK_L0},
    '{4'h4, 0, LINK_L0}, '{4'h3, 0, LINK_L2_ENTER},
    '{4'h0, 20, LINK_L2}, '{4'h1, 0, LINK_L2},
    '{4'h4, 0, LINK_L2_EXIT}, '{4'h0, 10, LINK_L0},
    '{4'h2, 0, LINK_L2_ENTER}, '{4'h0, 20, LINK_L2},
    '{4'h8, 0, LINK_L0}};

  hub_reset_and_link_power #(.POR_CYC(POR_T), .L2_IN_CYC(20), .L2_OUT_CYC(10))
  u_dut (.clk, .rst_b, .por_raw, .bus_reset, .set_address, .new_address,
    .set_config, .sleep_req, .suspend_req, .resume_req, .osc_en, .pll_en,
    .standby, .phy_en, .pair_oe, .core_rst_b, .usb_rst_b, .abort, .dn_reset,
    .dev_address, .configured, .suspended, .link_state, .link_busy);
  host_enum_model #(.ADDR(7'h2A)) u_host (.clk, .bus_reset, .set_address,
    .new_address, .set_config);

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic pulse(input logic [3:0] r);
    @(posedge clk);
    {bus_reset, resume_req, suspend_req, sleep_req} <= r;
    @(posedge clk);
    {bus_reset, resume_req, suspend_req, sleep_req} <= 4'h0;
    #1;
  endtask : pulse

  task automatic reach(input link_state_t e, input int max);
    int k;
    logic busy_exp;
    k = 0;
    busy_exp = e inside {LINK_L1_ENTER, LINK_L1_EXIT, LINK_L2_ENTER,
      LINK_L2_EXIT};
    while (link_state !== e && k < max)
    begin
      step(1);
      k++;
    end
    chk(7'(link_state), 7'(e));
    chk(7'({link_busy, suspended}), 7'({busy_exp, e == LINK_L2}));
  endtask : reach

  task automatic wait_core;
    int k;
    k = 0;
    while (core_rst_b !== 1'b1 && k < 40)
    begin
      step(1);
      k++;
    end
    chk(7'(core_rst_b), 7'h01);
  endtask : wait_core

  task automatic busrst;
    @(posedge clk);
    bus_reset <= 1'b1;
    #1;
    chk(bus_pins, 7'h03);
    @(posedge clk);
    bus_reset <= 1'b0;
    #1;
    chk(dev_address, 7'h00);
    chk(7'(configured), 7'h00);
  endtask : busrst

  task automatic end_sim;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // reset, enumeration, row table, then resets in mid-run
  initial
  begin
    step(15);
    chk(pins, 7'h12);
    @(posedge clk);
    rst_b <= 1'b1;
    wait_core();
    chk(pins, 7'h6C);
    busrst();
    step(4);
    chk(dev_address, 7'h2A);
    busrst();
    foreach (rows[i])
    begin
      if (rows[i].req != 4'h0)
        pulse(rows[i].req);
      reach(rows[i].exp, rows[i].max);
    end
    step(4);
    chk({configured, dev_address[5:0]}, 7'h6A);
    pulse(4'h1);
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    chk(dev_address, 7'h00);
    chk({3'h0, link_state, configured}, 7'h00);
    chk(pins, 7'h12);
    @(posedge clk);
    rst_b <= 1'b1;
    wait_core();
    @(posedge clk);
    por_raw <= 1'b1;
    #1;
    chk(7'(core_rst_b), 7'h00);
    @(posedge clk);
    por_raw <= 1'b0;
    step(POR_T + 1);
    chk(7'(core_rst_b), 7'h00);
    step(1);
    chk(7'(core_rst_b), 7'h01);
    wait_core();
    end_sim();
  end

  // watchdog well past the longest run
  initial
  begin
    #300000;
    errors++;
    end_sim();
  end
endmodule : tb_hub_reset_and_link_power
`default_nettype wire
